// [hdl/bcs_pkg.sv]
package bcs_pkg;
	// Table entry layout: opcode, label, parameter
	localparam int OP_W = 4;
	localparam int LABEL_W = 16;
	localparam int PARAM_W = 16;
	localparam int ENTRY_W = 36;
	localparam int OP_LSB = 32;
	localparam int LABEL_LSB = 16;
	localparam int PARAM_LSB = 0;

	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_RUN_TRANSFER = 4'h1;
	localparam logic [3:0] OP_ENTER_SUBTABLE = 4'h2;
	localparam logic [3:0] OP_LEAVE_SUBTABLE = 4'h3;
	localparam logic [3:0] OP_GOTO_LABEL = 4'h4;
	localparam logic [3:0] OP_RELATIVE_PASS = 4'h5;
	localparam logic [3:0] OP_AWAIT_TRIGGER = 4'h6;
	localparam logic [3:0] OP_PULSE_OUTPUT = 4'h7;
	localparam logic [3:0] OP_COUNT_DOWN_BRANCH = 4'h8;
	localparam logic [3:0] OP_AWAIT_SLOT = 4'h9;
	localparam logic [3:0] OP_STOP = 4'hA;
	localparam logic [3:0] OP_PAUSE = 4'hB;
	localparam logic [3:0] OP_SET_SLOT_PERIOD = 4'hC;
	localparam logic [3:0] OP_SWITCH_MAJOR_SEQUENCE = 4'hD;

	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int DELAY_UNIT_NS = 250;
	localparam int SLOT_UNIT_NS = 1000;
	localparam int STROBE_NS = 500;
	localparam int SLOT_UNIT_CYC = SLOT_UNIT_NS / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIME_W = 26;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_MEMWAIT = 3'b011,
		ST_EXEC = 3'b010,
		ST_WAIT = 3'b110,
		ST_SEARCH = 3'b111,
		ST_SRCHWAIT = 3'b101,
		ST_HALT = 3'b100
	} bcs_state_t;

	typedef enum logic [1:0] {
		WK_XFER = 2'b00,
		WK_TRIG = 2'b01,
		WK_SLOT = 2'b11,
		WK_DELAY = 2'b10
	} bcs_wait_t;
endpackage

// [hdl/bcs_frame_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module bcs_frame_timer (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic restart, // Restart slot timing from now
	input wire logic ext_mode, // Slots framed by trigger edges
	input wire logic ext_edge, // Synchronised trigger rising edge
	input wire logic period_load, // Load new slot period
	input wire logic [15:0] period_units, // Slot period in microseconds
	input wire logic dly_load, // Start a delay
	input wire logic [bcs_pkg::TIME_W-1:0] dly_cycles, // Delay length in clocks
	output logic slot_pulse, // One-cycle start of next slot
	output logic dly_busy // Delay still running
);
	logic [bcs_pkg::TIME_W-1:0] period_reg;
	logic [bcs_pkg::TIME_W-1:0] slot_cnt_reg;
	logic [bcs_pkg::TIME_W-1:0] dly_cnt_reg;
	logic [bcs_pkg::TIME_W-1:0] new_period;
	logic timer_hit;

	assign new_period = bcs_pkg::TIME_W'(period_units * bcs_pkg::SLOT_UNIT_CYC);
	// A zero period means no self-timed slots; only trigger edges in ext_mode can start one
	assign timer_hit = (period_reg != '0) && (slot_cnt_reg == bcs_pkg::TIME_W'(1));
	assign slot_pulse = ext_mode ? ext_edge : timer_hit;
	assign dly_busy = (dly_cnt_reg != '0);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			period_reg <= '0;
		end else if (period_load) begin
			period_reg <= new_period;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_cnt_reg <= '0;
		end else if (period_load) begin
			slot_cnt_reg <= new_period;
		end else if (restart || timer_hit) begin
			slot_cnt_reg <= period_reg;
		end else if (slot_cnt_reg != '0) begin
			slot_cnt_reg <= slot_cnt_reg - bcs_pkg::TIME_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dly_cnt_reg <= '0;
		end else if (dly_load) begin
			dly_cnt_reg <= dly_cycles;
		end else if (dly_busy) begin
			dly_cnt_reg <= dly_cnt_reg - bcs_pkg::TIME_W'(1);
		end
	end

	a_delay_length: assert property (@(posedge clk) disable iff (sys_rst)
		dly_load && dly_cycles == bcs_pkg::TIME_W'(3) |=> dly_busy [*3] ##1 !dly_busy)
		else $error("delay did not last its programmed length");
endmodule // bcs_frame_timer
`default_nettype wire

// [hdl/bcs_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module bcs_sequencer #(
	parameter int ADDR_W = 16
) (
	input wire logic clk, // System clock, 10 MHz
	input wire logic sys_rst, // Synchronous reset
	input wire logic seq_start, // Pulse: start at start_addr
	input wire logic [ADDR_W-1:0] start_addr, // First entry to run
	input wire logic [ADDR_W-1:0] tbl_last, // Last entry of table region
	input wire logic cyclic, // Major frame repeats with no count
	input wire logic [15:0] frame_count, // Major frame count loaded at start
	input wire logic [15:0] slot_period_init, // Minor period in us at start
	input wire logic ext_framing, // Slots begin on trigger edges
	input wire logic trig_in, // External trigger pin, asynchronous
	output logic mem_rd_en, // Table read request
	output logic [ADDR_W-1:0] mem_addr, // Table read address
	input wire logic mem_rd_valid, // Read data valid
	input wire logic [bcs_pkg::ENTRY_W-1:0] mem_rd_data, // Table entry
	output logic xfer_req, // Run transfer, held until done
	output logic [15:0] xfer_id, // Transfer to run
	input wire logic xfer_done, // Transfer engine finished
	output logic trig_out, // Strobe output pin
	output logic running, // Sequencer active
	output logic halted, // Stopped by halt or fault
	output logic label_miss, // Last search found no label
	output logic [15:0] frame_count_now // Remaining major frame count
);
	localparam logic [ADDR_W-1:0] ONE = ADDR_W'(1);

	if (ADDR_W < 2 || ADDR_W > 32) begin : g_bad_width
		$error("bcs_sequencer: ADDR_W must lie between 2 and 32");
	end

	function automatic logic [bcs_pkg::TIME_W-1:0] delay_cycles(input logic [15:0] units);
		// Round up: 250 ns is not a whole number of 100 ns clocks
		delay_cycles = bcs_pkg::TIME_W'((units * bcs_pkg::DELAY_UNIT_NS
			+ bcs_pkg::CLK_PERIOD_NS - 1) / bcs_pkg::CLK_PERIOD_NS);
	endfunction

	bcs_pkg::bcs_state_t state_reg;
	bcs_pkg::bcs_wait_t wait_reg;
	logic [ADDR_W-1:0] pc_reg;
	logic [ADDR_W-1:0] ret_reg;
	logic [ADDR_W-1:0] scan_reg;
	logic [15:0] target_reg;
	logic [bcs_pkg::ENTRY_W-1:0] entry_reg;
	logic [15:0] count_reg;
	logic [2:0] strobe_cnt_reg;
	logic xfer_req_reg;
	logic [15:0] xfer_id_reg;
	logic trig_pend_reg;
	logic slot_pend_reg;
	logic miss_reg;
	logic trig_s1_reg;
	logic trig_s2_reg;
	logic trig_s3_reg;

	wire [3:0] cur_op = entry_reg[bcs_pkg::OP_LSB +: bcs_pkg::OP_W];
	wire [15:0] cur_par = entry_reg[bcs_pkg::PARAM_LSB +: bcs_pkg::PARAM_W];
	wire [15:0] rd_label = mem_rd_data[bcs_pkg::LABEL_LSB +: bcs_pkg::LABEL_W];
	wire [ADDR_W-1:0] pc_inc = pc_reg + ONE;
	wire [ADDR_W-1:0] pc_skip = pc_inc + ADDR_W'(cur_par);
	wire trig_edge = trig_s2_reg && !trig_s3_reg;
	wire exec = (state_reg == bcs_pkg::ST_EXEC);
	wire start_ok = seq_start && (state_reg == bcs_pkg::ST_IDLE
		|| state_reg == bcs_pkg::ST_HALT);
	wire op_switch = exec && cur_op == bcs_pkg::OP_SWITCH_MAJOR_SEQUENCE;
	wire op_period = exec && cur_op == bcs_pkg::OP_SET_SLOT_PERIOD;
	wire op_pause = exec && cur_op == bcs_pkg::OP_PAUSE;
	wire cnt_zero_next = (count_reg <= 16'h0001);
	wire in_wait = (state_reg == bcs_pkg::ST_WAIT);
	wire slot_pulse;
	wire dly_busy;
	wire wait_over = (wait_reg == bcs_pkg::WK_XFER) ? xfer_done :
		(wait_reg == bcs_pkg::WK_TRIG) ? (trig_pend_reg || trig_edge) :
		(wait_reg == bcs_pkg::WK_SLOT) ? (slot_pend_reg || slot_pulse) :
		!dly_busy;

	assign mem_rd_en = (state_reg == bcs_pkg::ST_FETCH) || (state_reg == bcs_pkg::ST_SEARCH);
	assign mem_addr = (state_reg == bcs_pkg::ST_SEARCH) ? scan_reg : pc_reg;
	assign xfer_req = xfer_req_reg;
	assign xfer_id = xfer_id_reg;
	assign trig_out = (strobe_cnt_reg != 3'h0);
	assign running = (state_reg != bcs_pkg::ST_IDLE) && (state_reg != bcs_pkg::ST_HALT);
	assign halted = (state_reg == bcs_pkg::ST_HALT);
	assign label_miss = miss_reg;
	assign frame_count_now = count_reg;

	bcs_frame_timer u_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.restart(start_ok || op_switch),
		.ext_mode(ext_framing),
		.ext_edge(trig_edge),
		.period_load(start_ok || op_period),
		.period_units(start_ok ? slot_period_init : cur_par),
		.dly_load(op_pause),
		.dly_cycles(delay_cycles(cur_par)),
		.slot_pulse(slot_pulse),
		.dly_busy(dly_busy)
	);

	// The first stage is read by the second only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_s3_reg <= 1'b0;
		end else begin
			trig_s1_reg <= trig_in;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
		end
	end

	// Event flags cleared when a wait begins; a same-cycle event still sets them
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trig_pend_reg <= 1'b0;
			slot_pend_reg <= 1'b0;
		end else begin
			trig_pend_reg <= trig_edge || (trig_pend_reg && !(exec
				&& cur_op == bcs_pkg::OP_AWAIT_TRIGGER) && !in_wait);
			slot_pend_reg <= slot_pulse || (slot_pend_reg && !(exec
				&& cur_op == bcs_pkg::OP_AWAIT_SLOT) && !in_wait);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			strobe_cnt_reg <= 3'h0;
		end else if (exec && cur_op == bcs_pkg::OP_PULSE_OUTPUT) begin
			strobe_cnt_reg <= 3'(bcs_pkg::STROBE_CYC);
		end else if (strobe_cnt_reg != 3'h0) begin
			strobe_cnt_reg <= strobe_cnt_reg - 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= bcs_pkg::ST_IDLE;
			wait_reg <= bcs_pkg::WK_XFER;
			pc_reg <= '0;
			ret_reg <= '0;
			scan_reg <= '0;
			target_reg <= 16'h0000;
			entry_reg <= '0;
			count_reg <= 16'h0000;
			xfer_req_reg <= 1'b0;
			xfer_id_reg <= 16'h0000;
			miss_reg <= 1'b0;
		end else begin
			case (state_reg)
				bcs_pkg::ST_IDLE, bcs_pkg::ST_HALT: begin
					if (start_ok) begin
						pc_reg <= start_addr;
						count_reg <= frame_count;
						miss_reg <= 1'b0;
						state_reg <= bcs_pkg::ST_FETCH;
					end
				end
				bcs_pkg::ST_FETCH: begin
					// Running past the region end is the only limit on table size
					state_reg <= (pc_reg > tbl_last) ? bcs_pkg::ST_HALT
						: bcs_pkg::ST_MEMWAIT;
				end
				bcs_pkg::ST_MEMWAIT: begin
					if (mem_rd_valid) begin
						entry_reg <= mem_rd_data;
						state_reg <= bcs_pkg::ST_EXEC;
					end
				end
				bcs_pkg::ST_SEARCH: begin
					state_reg <= bcs_pkg::ST_SRCHWAIT;
				end
				bcs_pkg::ST_SRCHWAIT: begin
					if (mem_rd_valid) begin
						if (rd_label == target_reg) begin
							pc_reg <= scan_reg;
							state_reg <= bcs_pkg::ST_FETCH;
						end else if (scan_reg >= tbl_last) begin
							miss_reg <= 1'b1;
							state_reg <= bcs_pkg::ST_HALT;
						end else begin
							scan_reg <= scan_reg + ONE;
							state_reg <= bcs_pkg::ST_SEARCH;
						end
					end
				end
				bcs_pkg::ST_WAIT: begin
					if (wait_over) begin
						xfer_req_reg <= 1'b0;
						pc_reg <= pc_inc;
						state_reg <= bcs_pkg::ST_FETCH;
					end
				end
				default: begin
					// Execute; the plain advance is the fallback for no-ops and unknowns
					pc_reg <= pc_inc;
					state_reg <= bcs_pkg::ST_FETCH;
					scan_reg <= '0;
					target_reg <= cur_par;
					case (cur_op)
						bcs_pkg::OP_RUN_TRANSFER: begin
							pc_reg <= pc_reg;
							xfer_req_reg <= 1'b1;
							xfer_id_reg <= cur_par;
							wait_reg <= bcs_pkg::WK_XFER;
							state_reg <= bcs_pkg::ST_WAIT;
						end
						bcs_pkg::OP_ENTER_SUBTABLE: begin
							ret_reg <= pc_inc;
							state_reg <= bcs_pkg::ST_SEARCH;
						end
						bcs_pkg::OP_LEAVE_SUBTABLE: begin
							pc_reg <= ret_reg;
						end
						bcs_pkg::OP_GOTO_LABEL: begin
							state_reg <= bcs_pkg::ST_SEARCH;
						end
						bcs_pkg::OP_RELATIVE_PASS: begin
							pc_reg <= pc_skip;
						end
						bcs_pkg::OP_AWAIT_TRIGGER: begin
							pc_reg <= pc_reg;
							wait_reg <= bcs_pkg::WK_TRIG;
							state_reg <= bcs_pkg::ST_WAIT;
						end
						bcs_pkg::OP_COUNT_DOWN_BRANCH: begin
							if (!cyclic) begin
								count_reg <= cnt_zero_next ? 16'h0000 : count_reg - 16'h0001;
								if (cnt_zero_next) begin
									state_reg <= bcs_pkg::ST_SEARCH;
								end
							end
						end
						bcs_pkg::OP_AWAIT_SLOT: begin
							pc_reg <= pc_reg;
							wait_reg <= bcs_pkg::WK_SLOT;
							state_reg <= bcs_pkg::ST_WAIT;
						end
						bcs_pkg::OP_STOP: begin
							pc_reg <= pc_reg;
							state_reg <= bcs_pkg::ST_HALT;
						end
						bcs_pkg::OP_PAUSE: begin
							pc_reg <= pc_reg;
							wait_reg <= bcs_pkg::WK_DELAY;
							state_reg <= bcs_pkg::ST_WAIT;
						end
						bcs_pkg::OP_SWITCH_MAJOR_SEQUENCE: begin
							count_reg <= frame_count;
							state_reg <= bcs_pkg::ST_SEARCH;
						end
						default: begin
						end
					endcase
				end
			endcase
		end
	end

	a_nop_advance: assert property (@(posedge clk) disable iff (sys_rst)
		exec && cur_op == bcs_pkg::OP_NOP |=> state_reg == bcs_pkg::ST_FETCH
		&& pc_reg == $past(pc_reg) + ONE)
		else $error("no-operation did not advance to the next entry");

	a_xfer_request: assert property (@(posedge clk) disable iff (sys_rst)
		exec && cur_op == bcs_pkg::OP_RUN_TRANSFER |=> xfer_req && xfer_id == $past(cur_par)
		&& in_wait)
		else $error("transfer request not raised with its id");

	a_call_return_point: assert property (@(posedge clk) disable iff (sys_rst)
		exec && cur_op == bcs_pkg::OP_ENTER_SUBTABLE |=> ret_reg == $past(pc_reg) + ONE
		&& state_reg == bcs_pkg::ST_SEARCH && target_reg == $past(cur_par))
		else $error("call did not keep its return point");

	a_return_resume: assert property (@(posedge clk) disable iff (sys_rst)
		exec && cur_op == bcs_pkg::OP_LEAVE_SUBTABLE |=> pc_reg == $past(ret_reg)
		&& mem_rd_en && mem_addr == $past(ret_reg))
		else $error("return did not resume after the call");

	a_skip_distance: assert property (@(posedge clk) disable iff (sys_rst)
		exec && cur_op == bcs_pkg::OP_RELATIVE_PASS
		|=> pc_reg == $past(pc_reg) + ONE + ADDR_W'($past(cur_par)))
		else $error("skip passed the wrong number of entries");

	a_strobe_pulse: assert property (@(posedge clk) disable iff (sys_rst)
		exec && cur_op == bcs_pkg::OP_PULSE_OUTPUT |=> trig_out [*5] ##1 !trig_out)
		else $error("strobe pulse has the wrong width");

	a_trig_hold: assert property (@(posedge clk) disable iff (sys_rst)
		in_wait && wait_reg == bcs_pkg::WK_TRIG && !trig_pend_reg && !trig_edge
		|=> in_wait)
		else $error("trigger wait released without a trigger edge");

	a_slot_hold: assert property (@(posedge clk) disable iff (sys_rst)
		in_wait && wait_reg == bcs_pkg::WK_SLOT && !slot_pend_reg && !slot_pulse
		|=> in_wait)
		else $error("slot wait released before the slot began");

	a_count_branch: assert property (@(posedge clk) disable iff (sys_rst)
		exec && cur_op == bcs_pkg::OP_COUNT_DOWN_BRANCH && !cyclic && count_reg == 16'h0002
		|=> state_reg == bcs_pkg::ST_FETCH && count_reg == 16'h0001)
		else $error("counted jump branched before reaching zero");

	a_halt_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		halted && !seq_start |=> halted && !mem_rd_en)
		else $error("table fetched after halt");
endmodule // bcs_sequencer
`default_nettype wire

// [tb/bcs_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bcs_far_model (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic mem_rd_en, // Read request
	input wire logic [15:0] mem_addr, // Read address
	output logic mem_rd_valid, // Read data valid
	output logic [35:0] mem_rd_data, // Table entry
	input wire logic xfer_req, // Transfer request
	input wire logic [15:0] xfer_id, // Transfer number
	output logic xfer_done, // Transfer finished
	input wire logic [3:0] mem_lat // Read latency, 1 or more
);
	logic [35:0] tbl [64];
	logic [15:0] xlog [64];
	int xt [64];
	int nx, cyc;
	logic pend_reg, busy_reg;
	logic [3:0] rcnt_reg, xcnt_reg;
	logic [5:0] addr_reg;
	logic [35:0] last_reg;
	// Inverse of the last word outside valid, so stale data never passes
	assign mem_rd_valid = pend_reg && rcnt_reg == 4'h0;
	assign mem_rd_data = mem_rd_valid ? tbl[addr_reg] : ~last_reg;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		xfer_done <= 1'b0;
		if (sys_rst) begin
			pend_reg <= 1'b0;
			busy_reg <= 1'b0;
			last_reg <= 36'h0;
			nx <= 0;
			cyc <= 0;
		end else begin
			if (mem_rd_en) begin
				pend_reg <= 1'b1;
				rcnt_reg <= mem_lat - 4'h1;
				addr_reg <= mem_addr[5:0];
			end else if (mem_rd_valid) begin
				pend_reg <= 1'b0;
				last_reg <= mem_rd_data;
			end else if (pend_reg) begin
				rcnt_reg <= rcnt_reg - 4'h1;
			end
			// Skip the edge after done: the request is still high there
			if (xfer_req && !busy_reg && !xfer_done) begin
				busy_reg <= 1'b1;
				xcnt_reg <= 4'h3;
				xlog[nx] <= xfer_id;
				xt[nx] <= cyc;
				nx <= nx + 1;
			end else if (busy_reg && xcnt_reg == 4'h0) begin
				busy_reg <= 1'b0;
				xfer_done <= 1'b1;
			end else if (busy_reg) begin
				xcnt_reg <= xcnt_reg - 4'h1;
			end
		end
	end
endmodule // bcs_far_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, sys_rst = 1'b1, seq_start = 1'b0, cyclic = 1'b0;
	logic ext_framing = 1'b0, trig_in = 1'b0;
	logic [15:0] start_addr = 16'h0, tbl_last = 16'h3F, frame_count = 16'h0;
	logic [15:0] slot_period_init = 16'h0, mem_addr, xfer_id, frame_count_now;
	logic mem_rd_en, mem_rd_valid, xfer_req, xfer_done, trig_out, running, halted, label_miss;
	logic [35:0] mem_rd_data;
	logic [3:0] mem_lat = 4'h1;
	int n_fail, comparisons, cyc;

	bcs_sequencer #(.ADDR_W(16)) bcs_sequencer_i (.clk, .sys_rst, .seq_start, .start_addr,
		.tbl_last, .cyclic, .frame_count, .slot_period_init, .ext_framing, .trig_in,
		.mem_rd_en, .mem_addr, .mem_rd_valid, .mem_rd_data, .xfer_req, .xfer_id,
		.xfer_done, .trig_out, .running, .halted, .label_miss, .frame_count_now);
	bcs_far_model bcs_far_model_i (.clk, .sys_rst, .mem_rd_en, .mem_addr, .mem_rd_valid,
		.mem_rd_data, .xfer_req, .xfer_id, .xfer_done, .mem_lat);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Ceiling well above the thousand or so cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			$display("wrong value at %0t: run timed out", $time);
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
		end
	endtask
	task automatic chk_log(input logic [15:0] ex[$]);
		chk(bcs_far_model_i.nx, ex.size(), "transfer count");
		foreach (ex[i]) chk(bcs_far_model_i.xlog[i], ex[i], "transfer id");
	endtask
	task automatic put(input int i, input logic [3:0] op, input logic [15:0] lb,
		input logic [15:0] par);
		bcs_far_model_i.tbl[i] = {op, lb, par};
	endtask
	task automatic xf(input int i, input logic [15:0] lb, input logic [15:0] id);
		put(i, bcs_pkg::OP_RUN_TRANSFER, lb, id);
	endtask
	// Reset restores the mode, count, period and latency inputs; unused entries read as all-zero words
	task automatic boot();
		foreach (bcs_far_model_i.tbl[i]) bcs_far_model_i.tbl[i] = 36'h0;
		ext_framing = 1'b0;
		cyclic = 1'b0;
		slot_period_init = 16'h0;
		frame_count = 16'h0;
		mem_lat = 4'h1;
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
	endtask
	task automatic go(input logic [15:0] a);
		seq_start = 1'b1;
		start_addr = a;
		@(negedge clk);
		seq_start = 1'b0;
	endtask
	task automatic done();
		int k;
		k = 0;
		while (halted !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
	endtask
	function automatic int dcyc(input int p);
		return (p * bcs_pkg::DELAY_UNIT_NS + bcs_pkg::CLK_PERIOD_NS - 1) / bcs_pkg::CLK_PERIOD_NS;
	endfunction

	// Entry 0 stays all zero; slow memory answers every read
	task automatic t_flow();
		int n;
		boot();
		mem_lat = 4'h3;
		xf(1, 16'h0, 16'h5);
		put(2, bcs_pkg::OP_RELATIVE_PASS, 16'h0, 16'h2);
		xf(3, 16'h0, 16'h9);
		xf(4, 16'h0, 16'h9);
		put(5, 4'hE, 16'h0, 16'h9);
		xf(6, 16'h0, 16'h6);
		put(7, bcs_pkg::OP_STOP, 16'h0, 16'h0);
		xf(8, 16'h0, 16'h9);
		go(16'h0);
		done();
		chk_log('{16'h5, 16'h6});
		n = 0;
		repeat (20) begin
			@(negedge clk);
			if (mem_rd_en !== 1'b0) n++;
		end
		chk(n, 0, "fetch after halt");
		chk({halted, running}, 2'b10, "halt flags");
		$display("t_flow done");
	endtask

	// Nested call must return past the inner call, not the outer one
	task automatic t_call();
		boot();
		put(0, bcs_pkg::OP_ENTER_SUBTABLE, 16'h0, 16'h2222);
		xf(1, 16'h0, 16'h1);
		put(2, bcs_pkg::OP_GOTO_LABEL, 16'h0, 16'h4444);
		xf(3, 16'h2222, 16'h2);
		put(4, bcs_pkg::OP_LEAVE_SUBTABLE, 16'h0, 16'h0);
		put(5, bcs_pkg::OP_ENTER_SUBTABLE, 16'h4444, 16'h6666);
		xf(6, 16'h0, 16'h9);
		put(7, bcs_pkg::OP_STOP, 16'h0, 16'h0);
		put(8, bcs_pkg::OP_ENTER_SUBTABLE, 16'h6666, 16'h7777);
		xf(9, 16'h0, 16'h5);
		put(10, bcs_pkg::OP_STOP, 16'h0, 16'h0);
		xf(11, 16'h7777, 16'h3);
		put(12, bcs_pkg::OP_LEAVE_SUBTABLE, 16'h0, 16'h0);
		go(16'h0);
		done();
		chk_log('{16'h2, 16'h1, 16'h3, 16'h5});
		$display("t_call done");
	endtask

	task automatic t_miss();
		boot();
		put(0, bcs_pkg::OP_GOTO_LABEL, 16'h0, 16'h5555);
		xf(1, 16'h0, 16'h9);
		go(16'h0);
		done();
		chk({label_miss, halted, bcs_far_model_i.nx[7:0]}, 10'h300, "missing label");
		$display("t_miss done");
	endtask

	task automatic t_strobe();
		int n;
		boot();
		put(40, bcs_pkg::OP_PULSE_OUTPUT, 16'h0, 16'h0);
		put(41, bcs_pkg::OP_STOP, 16'h0, 16'h0);
		go(16'h28);
		n = 0;
		repeat (30) begin
			@(negedge clk);
			if (trig_out === 1'b1) n++;
		end
		chk(n, bcs_pkg::STROBE_CYC, "strobe width");
		chk(halted, 1'b1, "halt after strobe");
		$display("t_strobe done");
	endtask

	task automatic t_trig(input logic [3:0] op, input logic ext);
		boot();
		ext_framing = ext;
		put(0, op, 16'h0, 16'h0);
		xf(1, 16'h0, 16'h7);
		put(2, bcs_pkg::OP_STOP, 16'h0, 16'h0);
		go(16'h0);
		repeat (40) @(negedge clk);
		chk({running, bcs_far_model_i.nx[7:0]}, 9'h100, "released early");
		trig_in = 1'b1;
		repeat (4) @(negedge clk);
		trig_in = 1'b0;
		done();
		chk_log('{16'h7});
		$display("t_trig done");
	endtask

	// An odd count checks the rounding of part-cycle pauses
	task automatic t_pause();
		int t [2];
		logic [15:0] p [2] = '{16'h1, 16'hC};
		foreach (p[k]) begin
			boot();
			put(0, bcs_pkg::OP_PAUSE, 16'h0, p[k]);
			xf(1, 16'h0, 16'h3);
			put(2, bcs_pkg::OP_STOP, 16'h0, 16'h0);
			go(16'h0);
			done();
			t[k] = bcs_far_model_i.xt[0];
		end
		chk(t[1] - t[0], dcyc(12) - dcyc(1), "pause length");
		$display("t_pause done");
	endtask

	task automatic t_slot();
		boot();
		slot_period_init = 16'h3;
		put(0, bcs_pkg::OP_AWAIT_SLOT, 16'h0, 16'h0);
		xf(1, 16'h0, 16'h1);
		put(2, bcs_pkg::OP_AWAIT_SLOT, 16'h0, 16'h0);
		xf(3, 16'h0, 16'h2);
		put(4, bcs_pkg::OP_SET_SLOT_PERIOD, 16'h0, 16'h6);
		put(5, bcs_pkg::OP_AWAIT_SLOT, 16'h0, 16'h0);
		xf(6, 16'h0, 16'h3);
		put(7, bcs_pkg::OP_AWAIT_SLOT, 16'h0, 16'h0);
		xf(8, 16'h0, 16'h4);
		put(9, bcs_pkg::OP_STOP, 16'h0, 16'h0);
		go(16'h0);
		done();
		chk(bcs_far_model_i.xt[1] - bcs_far_model_i.xt[0], 3 * bcs_pkg::SLOT_UNIT_CYC,
			"slot period");
		chk(bcs_far_model_i.xt[3] - bcs_far_model_i.xt[2], 6 * bcs_pkg::SLOT_UNIT_CYC,
			"new slot period");
		$display("t_slot done");
	endtask

	task automatic t_major();
		boot();
		frame_count = 16'h2;
		xf(0, 16'h1111, 16'h1);
		put(1, bcs_pkg::OP_COUNT_DOWN_BRANCH, 16'h0, 16'h2222);
		put(2, bcs_pkg::OP_GOTO_LABEL, 16'h0, 16'h1111);
		xf(3, 16'h2222, 16'h2);
		put(4, bcs_pkg::OP_SWITCH_MAJOR_SEQUENCE, 16'h0, 16'h3333);
		xf(5, 16'h3333, 16'h3);
		put(6, bcs_pkg::OP_COUNT_DOWN_BRANCH, 16'h0, 16'h4444);
		put(7, bcs_pkg::OP_GOTO_LABEL, 16'h0, 16'h3333);
		put(8, bcs_pkg::OP_STOP, 16'h4444, 16'h0);
		go(16'h0);
		done();
		chk_log('{16'h1, 16'h1, 16'h2, 16'h3, 16'h3});
		chk(frame_count_now, 16'h0, "frame count");
		$display("t_major done");
	endtask

	// Cyclic major frame: the counted jump must fall through and keep the count
	task automatic t_cyclic();
		boot();
		cyclic = 1'b1;
		frame_count = 16'h1;
		put(0, bcs_pkg::OP_COUNT_DOWN_BRANCH, 16'h0, 16'h2222);
		xf(1, 16'h0, 16'h1);
		put(2, bcs_pkg::OP_STOP, 16'h0, 16'h0);
		xf(3, 16'h2222, 16'h2);
		go(16'h0);
		done();
		chk_log('{16'h1});
		chk(frame_count_now, 16'h1, "cyclic frame count");
		$display("t_cyclic done");
	endtask

	initial begin
		boot();
		chk({running, halted, xfer_req, trig_out, label_miss, frame_count_now}, 32'h0,
			"reset state");
		t_flow();
		t_call();
		t_miss();
		t_strobe();
		t_trig(bcs_pkg::OP_AWAIT_TRIGGER, 1'b0);
		t_trig(bcs_pkg::OP_AWAIT_SLOT, 1'b1);
		t_pause();
		t_slot();
		t_major();
		t_cyclic();
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
